// ---- led_bypass_pkg.sv ----
// Shared constants and types for the LED bypass command register bank
package led_bypass_pkg;

    localparam int NUM_CH = 8;
    localparam int CFG_W  = 14;
    localparam int CH_W   = 3;

    // Per-channel register field positions
    localparam int OPEN_HI  = 13;
    localparam int OPEN_LO  = 12;
    localparam int SHORT_HI = 11;
    localparam int SHORT_LO = 10;
    localparam int MODE_HI  = 9;
    localparam int MODE_LO  = 8;
    localparam int DIM_HI   = 7;
    localparam int DIM_LO   = 0;

    // Reset values and dimming limits
    localparam logic [7:0]       ALL_RESET = 8'hFF;
    localparam logic [CFG_W-1:0] CFG_RESET = 14'h3101;
    localparam logic [7:0]       DIM_MIN   = 8'h01;
    localparam logic [7:0]       DIM_ZERO  = 8'h00;

    // Device address prefixes, followed by the four address select pins
    localparam logic [2:0] ALL_PREFIX    = 3'h2;
    localparam logic [2:0] SINGLE_PREFIX = 3'h3;

    // Command byte layout of single-channel writes
    localparam int CMD_LONG_BIT = 7;
    localparam int CMD_CH_HI    = 6;
    localparam int CMD_CH_LO    = 4;
    localparam int CMD_THR_HI   = 3;
    localparam int CMD_THR_LO   = 2;
    localparam int CMD_MODE_HI  = 1;
    localparam int CMD_MODE_LO  = 0;

    // Channel mode codes
    localparam logic [1:0] MODE_LED_OFF  = 2'h0;
    localparam logic [1:0] MODE_LED_ON   = 2'h1;
    localparam logic [1:0] MODE_PWM      = 2'h2;
    localparam logic [1:0] MODE_PWM_FADE = 2'h3;

    // Serial framing: eight data bits then one acknowledge bit
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [3:0] LAST_BIT   = 4'h7;
    localparam logic [3:0] CNT_ONE    = 4'h1;
    localparam logic [7:0] EMPTY_BYTE = 8'h00;

    // Highest serial bit rates, in kbit/s
    localparam int STD_RATE_KBPS  = 100;
    localparam int FAST_RATE_KBPS = 400;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK,
        ST_IGNORE
    } link_state_t;

endpackage

// ---- level_sync.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module level_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t r;
    sync_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // Per bit: take the new level only where stages two and three match
        next_r.q  = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= {RST, RST, RST, RST};
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.q;

endmodule

// ---- channel_select.sv ----
// Picks the governing source for one channel switch
`timescale 1ns/1ps
module channel_select
    import led_bypass_pkg::*;
(
    input  wire logic       use_channel_i,
    input  wire logic       all_bit_i,
    input  wire logic [1:0] channel_mode_code_i,
    output logic      [1:0] effective_mode_o
);

    always_comb begin
        if (use_channel_i) begin
            effective_mode_o = channel_mode_code_i;
        end else if (all_bit_i) begin
            effective_mode_o = MODE_LED_ON;
        end else begin
            effective_mode_o = MODE_LED_OFF;
        end
    end

endmodule

// ---- led_bypass_command_registers.sv ----
// Serial slave port, holding latches and command registers of the LED bypass switch
`timescale 1ns/1ps
module led_bypass_command_registers
    import led_bypass_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      link_clk_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe_o,
    input  wire logic [3:0]                addr_sel_i,
    output logic      [7:0]                all_channel_switch_control_o,
    output logic      [NUM_CH*CFG_W-1:0]   channel_config_o,
    output logic      [NUM_CH-1:0]         channel_source_o,
    output logic      [2*NUM_CH-1:0]       effective_mode_o,
    output logic                           bus_busy_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Link-side state, clocked by the oversampling link clock

    typedef struct packed {
        link_state_t                   st;
        logic                          scl_q;
        logic                          sda_q;
        logic [3:0]                    cnt;
        logic [7:0]                    sh;
        logic [7:0]                    tx;
        logic                          rd;
        logic                          single;
        logic                          mack;
        logic                          expect_dim;
        logic [CH_W-1:0]               cur_ch;
        logic                          sda_low;
        logic                          busy;
        logic [7:0]                    all_hold;
        logic                          all_pend;
        logic [NUM_CH-1:0]             all_last;
        logic [NUM_CH-1:0][CFG_W-1:0]  ch_hold;
        logic [NUM_CH-1:0]             pend_open;
        logic [NUM_CH-1:0]             pend_long;
        logic                          req;
        logic                          wait_ack;
    } link_t;

    link_t r;
    link_t next_r;

    logic       scl_f;
    logic       sda_f;
    logic [3:0] addr_f;
    logic       ack_f;
    logic       ack_tgl;

    // Pins pass four flops; filter delay stays far below a fast-mode bit
    level_sync #(.W(1), .RST(1'b1)) u_scl_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (scl_i),
        .q_o     (scl_f)
    );

    level_sync #(.W(1), .RST(1'b1)) u_sda_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (sda_i),
        .q_o     (sda_f)
    );

    level_sync #(.W(4), .RST(4'h0)) u_addr_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (addr_sel_i),
        .q_o     (addr_f)
    );

    level_sync #(.W(1), .RST(1'b0)) u_ack_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (ack_tgl),
        .q_o     (ack_f)
    );

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic match_all;
    logic match_single;
    logic ack_done;

    always_comb begin
        scl_rise     = scl_f & ~r.scl_q;
        scl_fall     = ~scl_f & r.scl_q;
        start_seen   = scl_f & r.scl_q & r.sda_q & ~sda_f;
        stop_seen    = scl_f & r.scl_q & ~r.sda_q & sda_f;
        match_all    = (r.sh[7:1] == {ALL_PREFIX, addr_f});
        match_single = (r.sh[7:1] == {SINGLE_PREFIX, addr_f});
        ack_done     = r.wait_ack & (ack_f == r.req);
    end

    always_comb begin
        next_r       = r;
        next_r.scl_q = scl_f;
        next_r.sda_q = sda_f;

        // Holding latches stay frozen until the register side has copied them
        if (ack_done) begin
            next_r.wait_ack  = 1'b0;
            next_r.all_pend  = 1'b0;
            next_r.pend_open = '0;
            next_r.pend_long = '0;
        end

        if (start_seen) begin
            // Repeated START restarts decoding without freeing the bus
            next_r.st         = ST_ADDR;
            next_r.cnt        = '0;
            next_r.sda_low    = 1'b0;
            next_r.busy       = 1'b1;
            next_r.expect_dim = 1'b0;
        end else if (stop_seen) begin
            next_r.st      = ST_IDLE;
            next_r.sda_low = 1'b0;
            next_r.busy    = 1'b0;
            if (!next_r.wait_ack
                && (next_r.all_pend || (|next_r.pend_open) || (|next_r.pend_long))) begin
                next_r.req      = ~r.req;
                next_r.wait_ack = 1'b1;
            end
        end else begin
            unique case (r.st)
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        next_r.sh  = {r.sh[6:0], sda_f};
                        next_r.cnt = r.cnt + CNT_ONE;
                    end
                    if (scl_fall && r.cnt == BYTE_BITS) begin
                        if (r.st == ST_ADDR) begin
                            if (match_all || match_single) begin
                                next_r.rd      = r.sh[0];
                                next_r.single  = match_single;
                                next_r.sda_low = 1'b1;
                                next_r.st      = ST_ADDR_ACK;
                            end else begin
                                next_r.st = ST_IGNORE;
                            end
                        end else if (r.wait_ack) begin
                            // Latches busy with the previous commit: not acknowledged
                            next_r.st = ST_IGNORE;
                        end else begin
                            next_r.sda_low = 1'b1;
                            next_r.st      = ST_WRITE_ACK;
                            if (!r.single) begin
                                next_r.all_hold = r.sh;
                                next_r.all_pend = 1'b1;
                                next_r.all_last = '1;
                            end else if (r.expect_dim) begin
                                // Zero is not a legal duty
                                next_r.ch_hold[r.cur_ch][DIM_HI:DIM_LO] =
                                    (r.sh == DIM_ZERO) ? DIM_MIN : r.sh;
                                next_r.pend_long[r.cur_ch] = 1'b1;
                                next_r.all_last[r.cur_ch]  = 1'b0;
                                next_r.expect_dim          = 1'b0;
                            end else begin
                                next_r.cur_ch = r.sh[CMD_CH_HI:CMD_CH_LO];
                                next_r.ch_hold[r.sh[CMD_CH_HI:CMD_CH_LO]][MODE_HI:MODE_LO] =
                                    r.sh[CMD_MODE_HI:CMD_MODE_LO];
                                if (!r.sh[CMD_LONG_BIT]) begin
                                    next_r.ch_hold[r.sh[CMD_CH_HI:CMD_CH_LO]][OPEN_HI:OPEN_LO] =
                                        r.sh[CMD_THR_HI:CMD_THR_LO];
                                    next_r.pend_open[r.sh[CMD_CH_HI:CMD_CH_LO]] = 1'b1;
                                    next_r.all_last[r.sh[CMD_CH_HI:CMD_CH_LO]]  = 1'b0;
                                end else begin
                                    next_r.ch_hold[r.sh[CMD_CH_HI:CMD_CH_LO]][SHORT_HI:SHORT_LO] =
                                        r.sh[CMD_THR_HI:CMD_THR_LO];
                                    next_r.expect_dim = 1'b1;
                                end
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_r.cnt = '0;
                        if (r.rd) begin
                            // Read returns the held switch byte, then empty bytes
                            next_r.tx      = r.all_hold;
                            next_r.sda_low = ~r.all_hold[7];
                            next_r.st      = ST_READ;
                        end else begin
                            next_r.sda_low = 1'b0;
                            next_r.st      = ST_WRITE;
                        end
                    end
                end
                ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        next_r.sda_low = 1'b0;
                        next_r.cnt     = '0;
                        next_r.st      = ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        next_r.cnt = r.cnt + CNT_ONE;
                        if (r.cnt == LAST_BIT) begin
                            next_r.sda_low = 1'b0;
                            next_r.st      = ST_READ_ACK;
                        end else begin
                            next_r.tx      = {r.tx[6:0], 1'b0};
                            next_r.sda_low = ~r.tx[6];
                        end
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise) begin
                        next_r.mack = ~sda_f;
                    end
                    if (scl_fall) begin
                        if (r.mack) begin
                            next_r.tx      = EMPTY_BYTE;
                            next_r.sda_low = ~EMPTY_BYTE[7];
                            next_r.cnt     = '0;
                            next_r.st      = ST_READ;
                        end else begin
                            next_r.st = ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    next_r.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r            <= '0;
            r.st         <= ST_IDLE;
            r.scl_q      <= 1'b1;
            r.sda_q      <= 1'b1;
            r.all_hold   <= ALL_RESET;
            r.ch_hold    <= {NUM_CH{CFG_RESET}};
        end else begin
            r <= next_r;
        end
    end

    // Open drain: only a low level or release is ever offered
    assign sda_o    = 1'b0;
    assign sda_oe_o = r.sda_low;

    ////////////////////////////////////////////////////////////////////////////
    // Register side, clocked by clk_i

    typedef struct packed {
        logic                          ack;
        logic [7:0]                    all_reg;
        logic [NUM_CH-1:0][CFG_W-1:0]  cfg;
        logic [NUM_CH-1:0]             use_ch;
        logic [NUM_CH-1:0][1:0]        eff;
    } reg_t;

    reg_t q;
    reg_t next_q;

    logic                   req_f;
    logic                   busy_f;
    logic [NUM_CH-1:0][1:0] eff_sel;

    level_sync #(.W(1), .RST(1'b0)) u_req_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (r.req),
        .q_o     (req_f)
    );

    level_sync #(.W(1), .RST(1'b0)) u_busy_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (r.busy),
        .q_o     (busy_f)
    );

    for (genvar c = 0; c < NUM_CH; c++) begin : g_sel
        channel_select u_sel (
            .use_channel_i       (q.use_ch[c]),
            .all_bit_i           (q.all_reg[c]),
            .channel_mode_code_i (q.cfg[c][MODE_HI:MODE_LO]),
            .effective_mode_o    (eff_sel[c])
        );
    end

    // Latches are read only while the link side holds them frozen for this handshake
    always_comb begin
        next_q     = q;
        next_q.eff = eff_sel;
        if (req_f != q.ack) begin
            next_q.ack = req_f;
            if (r.all_pend) begin
                next_q.all_reg = r.all_hold;
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (r.pend_open[c]) begin
                    next_q.cfg[c][OPEN_HI:OPEN_LO] = r.ch_hold[c][OPEN_HI:OPEN_LO];
                    next_q.cfg[c][MODE_HI:MODE_LO] = r.ch_hold[c][MODE_HI:MODE_LO];
                end
                if (r.pend_long[c]) begin
                    next_q.cfg[c][SHORT_HI:DIM_LO] = r.ch_hold[c][SHORT_HI:DIM_LO];
                end
                // Latest writer governs; the all-channel byte itself is kept as is
                if ((r.pend_open[c] || r.pend_long[c]) && !(r.all_pend && r.all_last[c])) begin
                    next_q.use_ch[c] = 1'b1;
                end else if (r.all_pend) begin
                    next_q.use_ch[c] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q         <= '0;
            q.all_reg <= ALL_RESET;
            q.cfg     <= {NUM_CH{CFG_RESET}};
            q.use_ch  <= '0;
            q.eff     <= {NUM_CH{MODE_LED_ON}};
        end else begin
            q <= next_q;
        end
    end

    assign ack_tgl                      = q.ack;
    assign all_channel_switch_control_o = q.all_reg;
    assign channel_config_o             = q.cfg;
    assign channel_source_o             = q.use_ch;
    assign effective_mode_o             = q.eff;
    assign bus_busy_o                   = busy_f;

endmodule

// ---- led_bypass_monitor.sv ----
// Port checker of the LED bypass command register bank
`timescale 1ns/1ps
module led_bypass_monitor
    import led_bypass_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      link_clk_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_o,
    input  wire logic                      sda_oe_o,
    input  wire logic [7:0]                all_channel_switch_control_o,
    input  wire logic [NUM_CH*CFG_W-1:0]   channel_config_o,
    input  wire logic [NUM_CH-1:0]         channel_source_o,
    input  wire logic [2*NUM_CH-1:0]       effective_mode_o,
    input  wire logic                      bus_busy_o
);
    logic [2*NUM_CH-1:0] mode_exp;
    logic                dim_zero;
    always_comb begin
        dim_zero = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            mode_exp[2*c+:2] = channel_source_o[c] ? channel_config_o[CFG_W*c+MODE_LO+:2]
                                                   : {1'b0, all_channel_switch_control_o[c]};
            dim_zero = dim_zero | (channel_config_o[CFG_W*c+:8] == DIM_ZERO);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    open_drain_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        sda_o == 1'b0) else $error("data line driven high");
    reset_values_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !$past(rst_n_i) |-> all_channel_switch_control_o == ALL_RESET && channel_source_o == '0
        && channel_config_o == {NUM_CH{CFG_RESET}}) else $error("reset values wrong");
    commit_at_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_busy_o && $past(bus_busy_o) |-> $stable(all_channel_switch_control_o)
        && $stable(channel_config_o)) else $error("register changed mid transfer");
    governing_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        effective_mode_o == $past(mode_exp)) else $error("governing mode wrong");
    dim_nonzero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !dim_zero) else $error("zero dimming value stored");
    idle_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !bus_busy_o |-> !sda_oe_o) else $error("data pulled on idle bus");
    ack_hold_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $rose(sda_oe_o) |=> sda_oe_o [*8]) else $error("pull too short");
    data_change_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $changed(sda_oe_o) |-> !scl_i) else $error("data changed with clock high");
    cover property (@(posedge link_clk_i) disable iff (!rst_n_i) $rose(sda_oe_o));
    cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(bus_busy_o));
    cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(channel_source_o != '0));
endmodule
bind led_bypass_command_registers led_bypass_monitor i_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .all_channel_switch_control_o(all_channel_switch_control_o),
    .channel_config_o(channel_config_o), .channel_source_o(channel_source_o),
    .effective_mode_o(effective_mode_o), .bus_busy_o(bus_busy_o));

// ---- i2c_master_model.sv ----
// Bus master model driving the serial clock and the pulled-up data line
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic pull_low;
    logic s;
    // Pull-up: released line reads high
    assign sda_o = !(pull_low || sda_oe_i);
    initial begin
        scl_o = 1'b1;
        pull_low = 1'b0;
    end
    // Quarter bit of 25 cycles gives 400 kbit/s
    task q();
        repeat (25) @(posedge clk_i);
        #1;
    endtask
    task start();
        pull_low = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        pull_low = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task stop();
        pull_low = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        pull_low = 1'b0;
        q();
    endtask
    task bit_io(input logic b, output logic r);
        pull_low = !b;
        q();
        scl_o = 1'b1;
        q();
        r = sda_o;
        q();
        scl_o = 1'b0;
        q();
    endtask
    // Eight bits MSB first, then the ninth bit driven as b9
    task byte_io(input logic [7:0] d, input logic b9, output logic [7:0] g, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], g[i]);
        bit_io(b9, s);
        a = !s;
    endtask
endmodule

// ---- led_bypass_command_registers_bench.sv ----
// Self-checking bench of the LED bypass command register bank
`timescale 1ns/1ps
module led_bypass_command_registers_bench import led_bypass_pkg::*;;
    localparam logic [3:0] SEL = 4'hA;
    logic                    clk, link_clk, rst_n, scl, sda, sda_d, sda_oe, busy;
    logic [7:0]              all_sw, eall;
    logic [NUM_CH*CFG_W-1:0] cfg, ecfg;
    logic [NUM_CH-1:0]       src, esrc;
    logic [2*NUM_CH-1:0]     eff;
    logic [3:0]              addr_sel;
    int                      n_fail, n_tests;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    led_bypass_command_registers i_dut (.clk_i(clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel),
        .all_channel_switch_control_o(all_sw), .channel_config_o(cfg),
        .channel_source_o(src), .effective_mode_o(eff), .bus_busy_o(busy));
    i2c_master_model i_master (.clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [111:0] seen, input logic [111:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Commit lands some cycles after the bus goes free
    task settle();
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
        if (busy !== 1'b0) begin
            n_fail++;
            give_verdict();
        end
        repeat (20) @(posedge clk);
        #1;
    endtask
    task check_all();
        logic [2*NUM_CH-1:0] em;
        for (int c = 0; c < NUM_CH; c++)
            em[2*c+:2] = esrc[c] ? ecfg[CFG_W*c+MODE_LO+:2] : {1'b0, eall[c]};
        check(all_sw, eall);
        check(cfg, ecfg);
        check(src, esrc);
        check(eff, em);
    endtask
    task wr(input logic [6:0] adr, input logic [15:0] d, input int n, input logic ack);
        logic [7:0] g;
        logic       a;
        i_master.start();
        i_master.byte_io({adr, 1'b0}, 1'b1, g, a);
        check(a, ack);
        for (int k = n; k > 0; k--) begin
            i_master.byte_io(d[8*k-1-:8], 1'b1, g, a);
            check(a, ack);
        end
        i_master.stop();
        settle();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset();
        eall = ALL_RESET;
        ecfg = {NUM_CH{CFG_RESET}};
        esrc = '0;
        check_all();
        check(busy, 1'b0);
        check(sda_oe, 1'b0);
        check(sda_d, 1'b0);
        $display("Test reset done");
    endtask
    task t_all();
        wr({ALL_PREFIX, SEL}, 16'h000F, 1, 1'b1);
        eall = 8'h0F;
        check_all();
        $display("Test all-channel write done");
    endtask
    // Every mode, open and short code; dimming 0, 85, 170, 255
    task t_modes();
        for (int m = 0; m < 4; m++) begin
            logic [7:0] dv;
            dv = (m == 0) ? DIM_MIN : 8'(m * 85);
            wr({SINGLE_PREFIX, SEL}, {8'h00, 1'b0, 3'h7, 2'(m), 2'(m)}, 1, 1'b1);
            ecfg[CFG_W*7+OPEN_LO+:2] = 2'(m);
            ecfg[CFG_W*7+MODE_LO+:2] = 2'(m);
            esrc[7] = 1'b1;
            wr({SINGLE_PREFIX, SEL}, {4'hE, 2'(m), 2'(m), 8'(m * 85)}, 2, 1'b1);
            ecfg[CFG_W*6+:12] = {2'(m), 2'(m), dv};
            esrc[6] = 1'b1;
            check_all();
        end
        $display("Test channel modes done");
    endtask
    task t_hold();
        logic [7:0] g;
        logic       a;
        i_master.start();
        i_master.byte_io({ALL_PREFIX, SEL, 1'b0}, 1'b1, g, a);
        i_master.byte_io(8'h3C, 1'b1, g, a);
        check(a, 1'b1);
        i_master.start();
        check(busy, 1'b1);
        i_master.byte_io({SINGLE_PREFIX, SEL, 1'b1}, 1'b1, g, a);
        check(a, 1'b1);
        i_master.byte_io(8'hFF, 1'b0, g, a);
        check(g, 8'h3C);
        i_master.byte_io(8'hFF, 1'b1, g, a);
        check(g, EMPTY_BYTE);
        check_all();
        i_master.stop();
        settle();
        eall = 8'h3C;
        esrc = '0;
        check_all();
        $display("Test held byte and repeated start done");
    endtask
    task t_miss();
        wr({ALL_PREFIX, ~SEL}, 16'h00AA, 1, 1'b0);
        wr({3'h6, SEL}, 16'h00AA, 1, 1'b0);
        check_all();
        // Select pins moved: the device now answers only the new address
        addr_sel = ~SEL;
        wr({ALL_PREFIX, ~SEL}, 16'h00A5, 1, 1'b1);
        eall = 8'hA5;
        check_all();
        addr_sel = SEL;
        $display("Test foreign address done");
    endtask
    initial begin
        rst_n = 1'b0;
        addr_sel = SEL;
        n_fail = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_all();
        t_modes();
        t_hold();
        t_miss();
        give_verdict();
    end
endmodule
